// File: hdl/dma_global_control_regs.sv
`timescale 1ns/1ns
// Behaviour
// - With the emulation bit clear, a breakpoint suspends all channel transfers.
// - With the emulation bit set, transfers carry on through a breakpoint.
// - With exclusive access clear, the host port shares RAM and may reach both RAM ports and external memory.
// - With exclusive access set, channels needing a RAM port are held suspended.
// - With exclusive access set, the host port may reach only RAM, not external memory.
// - The host port is never granted the peripheral port.
// - The host priority bit gives the host low priority at 0 and high at 1.
// - Under exclusive access, host priority has no effect at the RAM ports.
// - Bits 15 to 4 of global control read as zero and ignore writes.
// - Both global registers are 16 bits, I/O mapped and read/write.
// - In original mode each channel uses shared element and frame indexes.
// - In enhanced mode the shared indexes are source only, with separate destination ones.
// - Compatibility bit 0 selects original at 0 and enhanced at 1; other bits read zero.
module dma_global_control_regs
   import dma_global_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   input  wire logic                  io_sel,
   input  wire logic                  io_wr,
   input  wire logic [IO_ADDR_W-1:0]  io_addr,
   input  wire logic [REG_W-1:0]      io_wdata,
   output logic      [REG_W-1:0]      io_rdata,
   input  wire logic                  emu_breakpoint,
   input  wire logic                  chan_needs_ram,
   input  wire logic                  host_req,
   input  wire dma_global_pkg::mem_port_e host_port_sel,
   input  wire logic [REG_W-1:0]      chan_element_index,
   input  wire logic [REG_W-1:0]      chan_frame_index,
   input  wire logic [REG_W-1:0]      chan_dst_element_index,
   input  wire logic [REG_W-1:0]      chan_dst_frame_index,
   output logic                       dma_suspend,
   output logic                       chan_ram_hold,
   output logic                       host_grant,
   output logic                       host_service_priority,
   output logic                       ram_prio_active,
   output logic      [REG_W-1:0]      chan_src_element_index,
   output logic      [REG_W-1:0]      chan_src_frame_index,
   output logic      [REG_W-1:0]      dest_element_index,
   output logic      [REG_W-1:0]      dest_frame_index
);
   import dma_global_pkg::*;

   logic [REG_W-1:0] dma_global_control_reg;
   logic [REG_W-1:0] dma_index_compat_control_reg;
   logic             host_exclusive_access;
   logic             emu_free;
   logic             dest_index_mode;
   logic             bkpt_sync1_reg;
   logic             bkpt_sync2_reg;

   function automatic logic reg_hit(input logic [IO_ADDR_W-1:0] a,
                                    input logic [IO_ADDR_W-1:0] target);
      reg_hit = io_sel && (a == target);
   endfunction : reg_hit

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dma_global_control_reg <= GLOBAL_CTRL_RST;
      end else if (io_wr && reg_hit(io_addr, GLOBAL_CTRL_ADDR)) begin
         dma_global_control_reg <= io_wdata & GLOBAL_CTRL_MASK;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         dma_index_compat_control_reg <= INDEX_COMPAT_RST;
      end else if (io_wr && reg_hit(io_addr, INDEX_COMPAT_ADDR)) begin
         dma_index_compat_control_reg <= io_wdata & INDEX_COMPAT_MASK;
      end
   end

   // Read mux
   always_comb begin
      io_rdata = '0;
      if (reg_hit(io_addr, GLOBAL_CTRL_ADDR)) begin
         io_rdata = dma_global_control_reg;
      end else if (reg_hit(io_addr, INDEX_COMPAT_ADDR)) begin
         io_rdata = dma_index_compat_control_reg;
      end
   end

   // Breakpoint synchroniser
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bkpt_sync1_reg <= 1'b0;
         bkpt_sync2_reg <= 1'b0;
      end else begin
         bkpt_sync1_reg <= emu_breakpoint;
         bkpt_sync2_reg <= bkpt_sync1_reg;
      end
   end

   assign host_exclusive_access = dma_global_control_reg[HOST_EXCL_BIT];
   assign emu_free              = dma_global_control_reg[EMU_FREE_BIT];
   assign dest_index_mode       = dma_index_compat_control_reg[DEST_INDEX_MODE_BIT];

   assign dma_suspend = bkpt_sync2_reg && !emu_free;

   assign chan_ram_hold = host_exclusive_access && chan_needs_ram;

   // Host grant decode
   always_comb begin
      host_grant = 1'b0;
      unique case (host_port_sel)
         PORT_DUAL_ACCESS_RAM_PORT_SEL,
         PORT_SINGLE_ACCESS_RAM_PORT_SEL: host_grant = host_req;
         PORT_EXTMEM_SEL: host_grant = host_req && !host_exclusive_access;
         PORT_PERIPH_SEL: host_grant = 1'b0;
      endcase
   end

   assign host_service_priority = dma_global_control_reg[HOST_PRIO_BIT];
   assign ram_prio_active = host_service_priority && !host_exclusive_access;

   assign chan_src_element_index = chan_element_index;
   assign chan_src_frame_index   = chan_frame_index;
   assign dest_element_index = dest_index_mode ? chan_dst_element_index : chan_element_index;
   assign dest_frame_index   = dest_index_mode ? chan_dst_frame_index : chan_frame_index;
endmodule : dma_global_control_regs

// File: common/dma_global_pkg.sv
package dma_global_pkg;
   // Register word width and I/O index of each global register
   localparam int               REG_W            = 16;
   localparam int               IO_ADDR_W        = 4;
   localparam logic [3:0]       GLOBAL_CTRL_ADDR = 4'h0;
   localparam logic [3:0]       INDEX_COMPAT_ADDR = 4'h1;
   // Global control field positions
   localparam int               HOST_PRIO_BIT    = 0;
   localparam int               HOST_EXCL_BIT    = 1;
   localparam int               EMU_FREE_BIT     = 2;
   localparam int               KEEP_ONE_BIT     = 3;
   localparam logic [15:0]      GLOBAL_CTRL_MASK = 16'h000f;
   // Compatibility register field positions
   localparam int               DEST_INDEX_MODE_BIT = 0;
   localparam logic [15:0]      INDEX_COMPAT_MASK   = 16'h0001;
   // Reset values
   localparam logic [15:0]      GLOBAL_CTRL_RST  = 16'h0008;
   localparam logic [15:0]      INDEX_COMPAT_RST = 16'h0000;
   // Memory ports seen by the host port
   typedef enum logic [1:0] {
      PORT_DUAL_ACCESS_RAM_PORT_SEL,
      PORT_SINGLE_ACCESS_RAM_PORT_SEL,
      PORT_EXTMEM_SEL,
      PORT_PERIPH_SEL
   } mem_port_e;
endpackage : dma_global_pkg

// File: sim/dma_global_regs_monitor.sv
`timescale 1ns/1ns
module dma_global_regs_monitor
   import dma_global_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        io_sel,
   input wire logic        io_wr,
   input wire logic [3:0]  io_addr,
   input wire logic [15:0] io_wdata,
   input wire logic        emu_breakpoint,
   input wire logic        chan_needs_ram,
   input wire logic        host_req,
   input wire dma_global_pkg::mem_port_e host_port_sel,
   input wire logic        dma_suspend,
   input wire logic        chan_ram_hold,
   input wire logic        host_grant,
   input wire logic        host_service_priority,
   input wire logic        ram_prio_active
);
   logic [2:0] gcr_reg;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) gcr_reg <= 3'h0;
      else if (io_sel && io_wr && io_addr == GLOBAL_CTRL_ADDR) gcr_reg <= io_wdata[2:0];
   end
   sequence bkpt_held; emu_breakpoint [*3]; endsequence
   sequence ext_req; host_req && host_port_sel == PORT_EXTMEM_SEL; endsequence
   a_bkpt_stop: assert property (bkpt_held ##0 !gcr_reg[2] |-> dma_suspend)
      else $error("no suspend");
   a_bkpt_free: assert property (gcr_reg[2] |-> !dma_suspend) else $error("suspend");
   a_ext_grant: assert property (ext_req |-> host_grant == !gcr_reg[1])
      else $error("ext grant");
   a_ram_grant: assert property (host_req && host_port_sel < PORT_EXTMEM_SEL |-> host_grant)
      else $error("ram grant");
   a_periph_deny: assert property (host_port_sel == PORT_PERIPH_SEL |-> !host_grant)
      else $error("periph grant");
   a_host_idle: assert property (!host_req |-> !host_grant)
      else $error("idle grant");
   a_chan_hold: assert property (chan_ram_hold == (gcr_reg[1] && chan_needs_ram))
      else $error("hold");
   a_prio_level: assert property (host_service_priority == gcr_reg[0]) else $error("prio");
   a_prio_ram: assert property (ram_prio_active == (gcr_reg[0] && !gcr_reg[1]))
      else $error("ram prio");
endmodule : dma_global_regs_monitor
bind dma_global_control_regs dma_global_regs_monitor mon (.*);

// File: sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import dma_global_pkg::*;
   logic        core_clk = 0, rst = 1, io_sel = 0, io_wr = 0, emu_breakpoint = 0;
   logic        chan_needs_ram = 1, host_req = 1, dma_suspend, chan_ram_hold, host_grant;
   logic        host_service_priority, ram_prio_active;
   logic [3:0]  io_addr = 0;
   logic [15:0] io_wdata = 0, io_rdata, chan_src_element_index, chan_src_frame_index;
   logic [15:0] chan_element_index = 16'h1234, chan_frame_index = 16'h5678;
   logic [15:0] chan_dst_element_index = 16'h9abc, chan_dst_frame_index = 16'hdef0;
   logic [15:0] dest_element_index, dest_frame_index;
   mem_port_e   host_port_sel = PORT_DUAL_ACCESS_RAM_PORT_SEL;
   int          fail_count = 0, check_count = 0;
   dma_global_control_regs dut (.*);
   always #5 core_clk = ~core_clk;
   task automatic check(input logic [15:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(negedge core_clk) {io_sel, io_wr, io_addr, io_wdata} = {2'b11, a, d};
      @(negedge core_clk) {io_sel, io_wr} = 2'b00;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(negedge core_clk) {io_sel, io_addr} = {1'b1, a};
      #1 check(io_rdata, exp);
      io_sel = 0;
   endtask : rd
   task automatic t_regs;
      rd(4'h0, 16'h0008);
      rd(4'h1, 16'h0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h000f);
      wr(4'h1, 16'hffff);
      rd(4'h1, 16'h0001);
      check(dest_frame_index, chan_dst_frame_index);
      check(chan_src_element_index, chan_element_index);
      wr(4'h2, 16'hffff);
      rd(4'h2, 16'h0000);
      wr(4'h1, 16'h0000);
      #1 check(dest_element_index, chan_element_index);
      check(dest_frame_index, chan_frame_index);
   endtask : t_regs
   task automatic t_host;
      for (int x = 0; x < 2; x++) begin
         wr(4'h0, x ? 16'h000b : 16'h0009);
         check(ram_prio_active, !x);
         check(host_service_priority, 1);
         check(chan_ram_hold, x);
         for (int p = 0; p < 4; p++) begin
            @(negedge core_clk) host_port_sel = mem_port_e'(p);
            #1 check(host_grant, p < 2 || (p == 2 && !x));
         end
      end
      @(negedge core_clk) host_req = 0;
      host_port_sel = PORT_DUAL_ACCESS_RAM_PORT_SEL;
      chan_needs_ram = 0;
      #1 check(host_grant, 0);
      check(chan_ram_hold, 0);
      @(negedge core_clk) host_req = 1;
      chan_needs_ram = 1;
   endtask : t_host
   task automatic t_bkpt;
      wr(4'h0, 16'h0008);
      emu_breakpoint = 1;
      repeat (2) @(negedge core_clk);
      check(dma_suspend, 1);
      wr(4'h0, 16'h000c);
      check(dma_suspend, 0);
      emu_breakpoint = 0;
   endtask : t_bkpt
   task automatic t_reset;
      wr(4'h1, 16'h0001);
      @(negedge core_clk) rst = 1;
      @(negedge core_clk) rst = 0;
      rd(4'h0, 16'h0008);
      rd(4'h1, 16'h0000);
   endtask : t_reset
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (5) @(negedge core_clk);
      rst = 0;
      t_regs;
      t_host;
      t_bkpt;
      t_reset;
      end_of_test;
   end
   initial begin
      #20000;
      fail_count++;
      end_of_test;
   end
endmodule : testbench
